/* rtl/rgd_cfg.svh */
`ifndef RGD_CFG_SVH
`define RGD_CFG_SVH
// ==========================================
// address map constants and reset values
`define RGD_WORK_PREFIX 4'he
`define RGD_CFG_BANK 4'hf
`define RGD_LOW_PREFIX 4'h0
`define RGD_PORT_CFG_OFS 4'h0
`define RGD_STOP_REC_OFS 4'hb
`define RGD_WDOG_OFS 4'hf
`define RGD_PORT_CFG_RST 8'hfe
`define RGD_STOP_REC_RST 8'h20
`define RGD_WDOG_RST 8'h0d
`define RGD_PTR_RST 8'h00
`define RGD_PORT_LIMIT 8'h04
`define RGD_CTRL_BASE 8'hf0
// control-space address of the group pointer
`define RGD_PTR_ADDR 8'hfd
// value shown by byte outputs with nothing behind them
`define RGD_IDLE_BYTE 8'h00
`endif

/* rtl/rgd_cfg_bank.sv */
`timescale 1ns/1ps
`include "rgd_cfg.svh"
// ==========================================
// configuration bank storage: three registers, rest reserved
module rgd_cfg_bank (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [3:0] offset,
    input wire logic wr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    output logic hit
);
    logic [7:0] port_config_register;
    logic [7:0] stop_recovery_register;
    logic [7:0] watchdog_mode_register;
    logic [7:0] next_port_cfg;
    logic [7:0] next_stop_rec;
    logic [7:0] next_wdog;
    // config read mux
    // read side only: the decoder's hit lookup must not share a process
    // with the write strobe that it produces, or the two form a loop
    always_comb begin
        rdata = `RGD_IDLE_BYTE;
        hit = 1'b1;
        case (offset)
            `RGD_PORT_CFG_OFS: rdata = port_config_register;
            `RGD_STOP_REC_OFS: rdata = stop_recovery_register;
            `RGD_WDOG_OFS: rdata = watchdog_mode_register;
            default: hit = 1'b0;
        endcase
    end
    // next values; reserved offsets drop the write
    always_comb begin
        next_port_cfg = port_config_register;
        next_stop_rec = stop_recovery_register;
        next_wdog = watchdog_mode_register;
        if (wr) begin
            case (offset)
                `RGD_PORT_CFG_OFS: next_port_cfg = wdata;
                `RGD_STOP_REC_OFS: next_stop_rec = wdata;
                `RGD_WDOG_OFS: next_wdog = wdata;
                // no storage here, nothing to update
                default: ;
            endcase
        end
    end
    // register stage
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            port_config_register <= `RGD_PORT_CFG_RST;
            stop_recovery_register <= `RGD_STOP_REC_RST;
            watchdog_mode_register <= `RGD_WDOG_RST;
        end else begin
            port_config_register <= next_port_cfg;
            stop_recovery_register <= next_stop_rec;
            watchdog_mode_register <= next_wdog;
        end
    end
endmodule : rgd_cfg_bank

/* rtl/rgd_decode.sv */
`timescale 1ns/1ps
`include "rgd_cfg.svh"
module rgd_decode #(
    parameter int GPR_TOP = 239
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic req,
    input wire rgd_pkg::rgd_mode_type mode,
    input wire logic [7:0] addr,
    input wire logic wr,
    input wire logic [7:0] wdata,
    output logic ack,
    output logic [7:0] full_addr,
    output rgd_pkg::rgd_target_type target,
    output logic refused,
    output logic [7:0] rdata,
    output logic [7:0] group_pointer
);
    import rgd_pkg::*;
    // ==========================================
    // address formation
    logic [7:0] eff_addr;
    logic direct_blocked;
    rgd_target_type tgt;
    logic [3:0] bank_sel;
    logic cfg_wr;
    logic cfg_hit;
    logic [7:0] cfg_rdata;
    logic [7:0] next_group_pointer;
    logic next_ack;
    logic [7:0] next_full_addr;
    rgd_target_type next_target;
    logic next_refused;
    logic [7:0] next_rdata;
    logic [7:0] gpr_top_b;
    assign gpr_top_b = 8'(GPR_TOP);
    // classify one resolved 8-bit address
    function automatic rgd_target_type classify(input logic [7:0] a, input logic [7:0] top);
        if (a < `RGD_PORT_LIMIT) classify = RGD_T_PORT;
        else if (a >= `RGD_CTRL_BASE) classify = RGD_T_CTRL;
        else if (a <= top) classify = RGD_T_GPR;
        else classify = RGD_T_NONE;
    endfunction : classify
    // ==========================================
    // operand resolution
    // resolve mode to an address; kept apart from the target decode so
    // the config bank lookup does not close a loop through one process
    always_comb begin
        if (mode == RGD_M_WORKING)
            eff_addr = {group_pointer[7:4], addr[3:0]};
        else
            eff_addr = addr;
        // direct path to E bank blocked
        direct_blocked = (mode == RGD_M_DIRECT) && (addr[7:4] == `RGD_WORK_PREFIX);
        bank_sel = group_pointer[3:0];
    end
    // target class of the resolved address
    always_comb begin
        tgt = classify(eff_addr, gpr_top_b);
        if (eff_addr[7:4] == `RGD_LOW_PREFIX && bank_sel != `RGD_LOW_PREFIX) begin
            if (bank_sel == `RGD_CFG_BANK && cfg_hit) begin
                tgt = RGD_T_CFG;
            end else begin
                // no storage behind the other banks
                tgt = RGD_T_RSVD;
            end
        end
    end
    // config write strobe
    // a blocked direct access never reaches the bank
    assign cfg_wr = req && wr && !direct_blocked && (tgt == RGD_T_CFG);
    rgd_cfg_bank u_cfg (
        .mclk(mclk),
        .resetn(resetn),
        .offset(eff_addr[3:0]),
        .wr(cfg_wr),
        .wdata(wdata),
        .rdata(cfg_rdata),
        .hit(cfg_hit)
    );
    // ==========================================
    // pointer and answer next values
    always_comb begin
        next_group_pointer = group_pointer;
        next_ack = req;
        next_full_addr = full_addr;
        next_target = target;
        next_refused = 1'b0;
        next_rdata = rdata;
        if (req) begin
            next_full_addr = eff_addr;
            if (direct_blocked) begin
                // blocked access answers as nothing
                next_target = RGD_T_NONE;
                next_refused = 1'b1;
                next_rdata = `RGD_IDLE_BYTE;
            end else begin
                next_target = tgt;
                next_refused = (tgt == RGD_T_RSVD) || (tgt == RGD_T_NONE);
                if (wr && tgt == RGD_T_CTRL && eff_addr == `RGD_PTR_ADDR)
                    next_group_pointer = wdata;
                // reads return the value before any write of this cycle
                if (tgt == RGD_T_CFG) next_rdata = cfg_rdata;
                else if (tgt == RGD_T_CTRL && eff_addr == `RGD_PTR_ADDR) next_rdata = group_pointer;
                else next_rdata = `RGD_IDLE_BYTE;
            end
        end
    end
    // register stage; all outputs from flops
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            group_pointer <= `RGD_PTR_RST;
            ack <= 1'b0;
            full_addr <= `RGD_IDLE_BYTE;
            target <= RGD_T_NONE;
            refused <= 1'b0;
            rdata <= `RGD_IDLE_BYTE;
        end else begin
            group_pointer <= next_group_pointer;
            ack <= next_ack;
            full_addr <= next_full_addr;
            target <= next_target;
            refused <= next_refused;
            rdata <= next_rdata;
        end
    end
    // ==========================================
    // checks
    property p_work_prefix;
        @(posedge mclk) disable iff (!resetn)
        (req && mode == RGD_M_WORKING) |=> (full_addr[7:4] == $past(group_pointer[7:4]));
    endproperty
    a_work_prefix: assert property (p_work_prefix) else $error("working prefix wrong");
    property p_direct_e;
        @(posedge mclk) disable iff (!resetn)
        (req && mode == RGD_M_DIRECT && addr[7:4] == 4'he) |=> (refused && target == RGD_T_NONE);
    endproperty
    a_direct_e: assert property (p_direct_e) else $error("direct E bank reached");
    property p_ind_e;
        @(posedge mclk) disable iff (!resetn)
        (req && mode == RGD_M_INDIRECT && addr[7:4] == 4'he && GPR_TOP >= 239)
        |=> (target == RGD_T_GPR);
    endproperty
    a_ind_e: assert property (p_ind_e) else $error("indirect E bank refused");
    property p_rsvd;
        @(posedge mclk) disable iff (!resetn)
        (req && ((mode == RGD_M_WORKING) ? (group_pointer[7:4] == 4'h0)
                                          : (addr[7:4] == 4'h0))
         && group_pointer[3:0] != 4'h0 && group_pointer[3:0] != 4'hf)
        |=> (target == RGD_T_RSVD && rdata == 8'h00);
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bank answered");
    property p_ack;
        @(posedge mclk) disable iff (!resetn)
        req |=> ack;
    endproperty
    a_ack: assert property (p_ack) else $error("no answer");
    property p_ptr_wr;
        @(posedge mclk) disable iff (!resetn)
        (req && wr && mode == RGD_M_DIRECT && addr == 8'hfd) |=> (group_pointer == $past(wdata));
    endproperty
    a_ptr_wr: assert property (p_ptr_wr) else $error("pointer not written");
    property p_cfg;
        @(posedge mclk) disable iff (!resetn)
        (req && mode == RGD_M_DIRECT && addr == 8'h00 && group_pointer[3:0] == 4'hf)
        |=> (target == RGD_T_CFG);
    endproperty
    a_cfg: assert property (p_cfg) else $error("config bank missed");
    property p_bank0;
        @(posedge mclk) disable iff (!resetn)
        (req && mode == RGD_M_DIRECT && addr[7:2] == 6'h00 && group_pointer[3:0] == 4'h0)
        |=> (target == RGD_T_PORT);
    endproperty
    a_bank0: assert property (p_bank0) else $error("bank 0 not ports");
    // an idle cycle answers nothing
    property p_idle;
        @(posedge mclk) disable iff (!resetn)
        !req |=> (!ack && !refused);
    endproperty
    a_idle: assert property (p_idle) else $error("answer without request");
    // plain addresses pass through unchanged
    property p_full_plain;
        @(posedge mclk) disable iff (!resetn)
        (req && mode != RGD_M_WORKING) |=> (full_addr == $past(addr));
    endproperty
    a_full_plain: assert property (p_full_plain) else $error("plain address altered");
    // a short address keeps its own low nibble
    property p_work_low;
        @(posedge mclk) disable iff (!resetn)
        (req && mode == RGD_M_WORKING) |=> (full_addr[3:0] == $past(addr[3:0]));
    endproperty
    a_work_low: assert property (p_work_low) else $error("working offset wrong");
    // upper indirect space up to the top reaches general registers
    property p_gpr;
        @(posedge mclk) disable iff (!resetn)
        (req && mode == RGD_M_INDIRECT && addr[7:4] != 4'h0 && addr <= gpr_top_b)
        |=> (target == RGD_T_GPR);
    endproperty
    a_gpr: assert property (p_gpr) else $error("general register missed");
    // the top sixteen addresses are control space
    property p_ctrl;
        @(posedge mclk) disable iff (!resetn)
        (req && mode == RGD_M_INDIRECT && addr[7:4] == 4'hf) |=> (target == RGD_T_CTRL);
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("control space missed");
    // bank 0 leaves the low addresses unbanked
    property p_bank_zero;
        @(posedge mclk) disable iff (!resetn)
        (req && mode == RGD_M_INDIRECT && addr[7:4] == 4'h0 && group_pointer[3:0] == 4'h0)
        |=> (target != RGD_T_RSVD && target != RGD_T_CFG);
    endproperty
    a_bank_zero: assert property (p_bank_zero) else $error("bank 0 expanded");
    // the pointer moves only on a write
    property p_ptr_hold;
        @(posedge mclk) disable iff (!resetn)
        !(req && wr) |=> $stable(group_pointer);
    endproperty
    a_ptr_hold: assert property (p_ptr_hold) else $error("pointer changed unasked");
endmodule : rgd_decode

/* rtl/rgd_pkg.sv */
// ==========================================
// shared types
package rgd_pkg;
    // resolved target of an access
    typedef enum logic [2:0] {
        RGD_T_NONE = 3'b000,
        RGD_T_PORT = 3'b001,
        RGD_T_GPR = 3'b010,
        RGD_T_CTRL = 3'b011,
        RGD_T_CFG = 3'b100,
        RGD_T_RSVD = 3'b101
    } rgd_target_type;
    // addressing mode of the operand
    typedef enum logic [1:0] {
        RGD_M_DIRECT = 2'b00,
        RGD_M_INDIRECT = 2'b01,
        RGD_M_WORKING = 2'b10
    } rgd_mode_type;
endpackage : rgd_pkg

/* verification/rgd_core_model.sv */
`timescale 1ns/1ps
// ==========================================
// core side: one operand access per cycle
module rgd_core_model (
    input wire logic mclk,
    output logic req,
    output rgd_pkg::rgd_mode_type mode,
    output logic [7:0] addr,
    output logic wr,
    output logic [7:0] wdata
);
    import rgd_pkg::*;
    // idle lines at time zero
    initial begin
        req = 1'b0;
        mode = RGD_M_DIRECT;
        addr = 8'h00;
        wr = 1'b0;
        wdata = 8'h00;
    end
    // caller is just past an edge; held until the next edge
    task automatic put(input rgd_mode_type m, input logic [7:0] a, input logic w,
        input logic [7:0] d);
        req = 1'b1;
        mode = m;
        addr = a;
        wr = w;
        wdata = d;
    endtask : put
    // released lines flip so a stale value never looks valid
    task automatic idle();
        req = 1'b0;
        wr = 1'b0;
        addr = ~addr;
        wdata = ~wdata;
    endtask : idle
endmodule : rgd_core_model

/* verification/tb_top.sv */
`timescale 1ns/1ps
// ==========================================
// decoder bench: core accesses against an integer model
module tb_top;
    import rgd_pkg::*;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic req, wr, ack, refused;
    rgd_mode_type mode;
    rgd_target_type target;
    logic [7:0] addr, wdata, full_addr, rdata, group_pointer, p;
    int mismatches, num_checks, ptr;
    int cfg[3] = '{8'hfe, 8'h20, 8'h0d}; // model config bank
    logic [7:0] tbl[8] = '{8'h00, 8'h03, 8'h04, 8'hdf, 8'he0, 8'hef, 8'hf0, 8'hff};
    always #2 mclk = ~mclk;
    rgd_core_model rgd_core_model_i (.mclk(mclk), .req(req), .mode(mode), .addr(addr),
        .wr(wr), .wdata(wdata));
    rgd_decode #(.GPR_TOP(239)) rgd_decode_i (.mclk(mclk), .resetn(resetn), .req(req),
        .mode(mode), .addr(addr), .wr(wr), .wdata(wdata), .ack(ack), .full_addr(full_addr),
        .target(target), .refused(refused), .rdata(rdata), .group_pointer(group_pointer));
    // one compare for every byte-sized result
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", n, e, g);
            mismatches++;
        end
    endtask : chk
    // predict, issue back to back, compare one edge later
    task automatic acc(input rgd_mode_type m, input logic [7:0] a, input logic w,
        input logic [7:0] d);
        int fa, bk, et, er, ed, ix;
        fa = (m == RGD_M_WORKING) ? ((ptr & 8'hf0) | (a & 8'h0f)) : a;
        bk = ptr & 8'h0f;
        ix = -1;
        et = RGD_T_NONE;
        if (m == RGD_M_DIRECT && fa >= 8'he0 && fa <= 8'hef) et = RGD_T_NONE;
        else if (fa < 16 && bk != 0) begin
            if (bk == 15) ix = (fa == 0) ? 0 : (fa == 11) ? 1 : (fa == 15) ? 2 : -1;
            et = (ix < 0) ? RGD_T_RSVD : RGD_T_CFG;
        end
        else if (fa < 4) et = RGD_T_PORT;
        else if (fa <= 239) et = RGD_T_GPR;
        else if (fa >= 240) et = RGD_T_CTRL;
        er = (et == RGD_T_NONE || et == RGD_T_RSVD);
        ed = (ix >= 0) ? cfg[ix] : (et == RGD_T_CTRL && fa == 8'hfd) ? ptr : 0;
        if (w && ix >= 0) cfg[ix] = d;
        if (w && et == RGD_T_CTRL && fa == 8'hfd) ptr = d;
        rgd_core_model_i.put(m, a, w, d);
        @(posedge mclk);
        #1;
        chk("ack", 8'h01, {7'h00, ack});
        chk("target", 8'(et), {5'h00, target});
        chk("refused", 8'(er), {7'h00, refused});
        chk("rdata", 8'(ed), rdata);
        chk("full_addr", 8'(fa), full_addr);
        chk("group_pointer", 8'(ptr), group_pointer);
    endtask : acc
    // every registered output at its reset level
    task automatic rst_chk();
        chk("ack", 8'h00, {7'h00, ack});
        chk("target", 8'h00, {5'h00, target});
        chk("refused", 8'h00, {7'h00, refused});
        chk("rdata", 8'h00, rdata);
        chk("full_addr", 8'h00, full_addr);
        chk("group_pointer", 8'h00, group_pointer);
    endtask : rst_chk
    // closing report
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_of_test
    // ==========================================
    // main sequence
    initial begin
        void'($urandom(32'h131e));
        repeat (6) @(posedge mclk);
        #1;
        rst_chk();
        resetn = 1'b1;
        // address classes, direct and indirect, bank 0
        for (int i = 0; i < 8; i++) begin
            acc(RGD_M_DIRECT, tbl[i], 1'b0, 8'h00);
            acc(RGD_M_INDIRECT, tbl[i], 1'b0, 8'h00);
        end
        $display("test classes done");
        // every expanded bank seen through 00, 0b, 0f, and group 0 short
        for (int b = 0; b < 16; b++) begin
            acc(RGD_M_DIRECT, 8'hfd, 1'b1, 8'(b));
            acc(RGD_M_DIRECT, 8'h00, 1'b0, 8'h00);
            acc(RGD_M_DIRECT, 8'h0b, 1'b0, 8'h00);
            acc(RGD_M_DIRECT, 8'h0f, 1'b0, 8'h00);
            acc(RGD_M_WORKING, 8'h3b, 1'b0, 8'h00);
        end
        // config writes, reserved offset drops the write
        acc(RGD_M_DIRECT, 8'h0b, 1'b1, 8'h5a);
        acc(RGD_M_DIRECT, 8'h05, 1'b1, 8'h33);
        acc(RGD_M_DIRECT, 8'h05, 1'b0, 8'h00);
        acc(RGD_M_DIRECT, 8'h0b, 1'b0, 8'h00);
        $display("test banks done");
        // reset in mid-run restores pointer and config bank
        rgd_core_model_i.idle();
        resetn = 1'b0;
        @(posedge mclk);
        #1;
        rst_chk();
        ptr = 0;
        cfg = '{8'hfe, 8'h20, 8'h0d};
        resetn = 1'b1;
        acc(RGD_M_DIRECT, 8'hfd, 1'b1, 8'h0f);
        acc(RGD_M_DIRECT, 8'h0b, 1'b0, 8'h00);
        acc(RGD_M_DIRECT, 8'h00, 1'b0, 8'h00);
        $display("test reset done");
        // random groups, short addresses
        repeat (20) begin
            p = {4'(1 + $urandom % 15), 4'($urandom)};
            acc(RGD_M_DIRECT, 8'hfd, 1'b1, p);
            repeat (3) acc(RGD_M_WORKING, 8'($urandom), 1'b0, 8'h00);
        end
        rgd_core_model_i.idle();
        @(posedge mclk);
        #1;
        chk("ack", 8'h00, {7'h00, ack});
        chk("refused", 8'h00, {7'h00, refused});
        $display("test working done");
        end_of_test();
    end
endmodule : tb_top
